// ---- verification/tb_unsigned_divide_16by8.sv ----
// self-checking bench for the unsigned divide datapath
`timescale 1ns/1ps
module tb_unsigned_divide_16by8;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic start = 1'b0;
  udv_pkg::udv_req_s req = '0;
  udv_pkg::udv_flags_s flags_in = '0;
  logic ready;
  logic done;
  udv_pkg::udv_rsp_s rsp;
  logic [15:0] pair_q;
  int mismatches = 0;
  int n_checks = 0;
  always #50 core_clk = ~core_clk;
  udv_divider dut (.core_clk(core_clk), .srst(srst), .start(start), .req(req),
    .flags_in(flags_in), .ready(ready), .done(done), .rsp(rsp));
  udv_regfile_model regs (.core_clk(core_clk), .srst(srst), .rsp(rsp), .pair_q(pair_q));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one divide; a refused start is pulsed mid-run to show it is ignored
  task automatic run(input logic [1:0] m, input logic [15:0] dvd, input logic [7:0] dvs);
    logic [23:0] cand;
    logic [15:0] q;
    logic [15:0] old;
    logic ov;
    int n;
    cand = {3{~dvs}};
    cand[8*(2-m)+:8] = dvs;
    q = (dvs == 8'h00) ? 16'h0000 : dvd / dvs;
    ov = q > 16'h00ff;
    old = pair_q;
    @(posedge core_clk);
    req <= {m, dvd, cand};
    flags_in <= {4'hf, dvd[1:0]};
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    n = 0;
    while (n < 40) begin
      #1;
      n++;
      if (done === 1'b1) break;
      @(posedge core_clk);
      start <= (n == 4);
    end
    chk("latency", (dvs == 8'h00) ? 16'd10 : 16'd26, 16'(n));
    chk("pair_we", 16'(dvs != 8'h00), 16'(rsp.pair_we));
    chk("flags", 16'({ov && q < 16'h0200, dvs == 8'h00 || q == 16'h0000,
      dvs != 8'h00 && q[7], dvs == 8'h00 || ov, dvd[1:0]}), 16'(rsp.flags));
    @(posedge core_clk);
    #1;
    chk("ready", 16'h0001, 16'(ready));
    if (dvs == 8'h00) chk("held pair", old, pair_q);
    else if (!ov) chk("pair", {8'(dvd % 16'(dvs)), q[7:0]}, pair_q);
  endtask : run
  task automatic t_modes();
    run(2'h0, 16'h1003, 8'h40);
    run(2'h1, 16'h1003, 8'h80);
    run(2'h2, 16'h1003, 8'h20);
  endtask : t_modes
  task automatic t_unsigned();
    run(2'h0, 16'hfe01, 8'hff);
    run(2'h2, 16'h8000, 8'h81);
  endtask : t_unsigned
  task automatic t_overflow();
    run(2'h1, 16'h0100, 8'h01);
    run(2'h0, 16'h01ff, 8'h01);
    run(2'h2, 16'h0200, 8'h01);
    run(2'h0, 16'hffff, 8'h01);
  endtask : t_overflow
  task automatic t_zero();
    run(2'h0, 16'h0005, 8'h10);
    run(2'h1, 16'h1234, 8'h00);
    run(2'h2, 16'h0000, 8'h00);
  endtask : t_zero
  // reset mid-divide: outputs return to idle, then a fresh divide runs
  task automatic t_reset();
    @(posedge core_clk);
    req <= {2'h0, 16'h1003, 24'h40bfbf};
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    repeat (3) @(posedge core_clk);
    srst <= 1'b1;
    @(posedge core_clk);
    srst <= 1'b0;
    #1;
    chk("reset ready", 16'h0001, 16'(ready));
    chk("reset done", 16'h0000, 16'(done));
    chk("reset pair", 16'h0000, rsp.pair);
    chk("reset flags", 16'h0000, 16'(rsp.flags));
    run(2'h0, 16'h1003, 8'h40);
  endtask : t_reset
  initial begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("idle ready", 16'h0001, 16'(ready));
    chk("idle pair", 16'h0000, rsp.pair);
    t_modes();
    t_unsigned();
    t_overflow();
    t_zero();
    t_reset();
    give_verdict();
  end
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
endmodule : tb_unsigned_divide_16by8

// ---- verification/udv_divider_monitor.sv ----
// checker for the unsigned divide datapath ports
`timescale 1ns/1ps
module udv_divider_monitor (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic start,
  input udv_pkg::udv_req_s req,
  input udv_pkg::udv_flags_s flags_in,
  input wire logic ready,
  input wire logic done,
  input udv_pkg::udv_rsp_s rsp
);
  logic [7:0] dvs;
  logic [15:0] exp_q;
  logic [1:0] dh_q;
  logic take;
  assign take = start && ready;
  assign dvs = (req.mode == udv_pkg::UDV_SRC_INDIRECT) ? req.indirect_register_operand :
    (req.mode == udv_pkg::UDV_SRC_IMMEDIATE) ? req.immediate_operand : req.register_operand;
  // expected pair captured at the accepted start; guarded so a zero divisor never divides
  always_ff @(posedge core_clk) begin
    if (take && dvs != 8'h00) begin
      exp_q <= {8'(req.register_pair_operand % 16'(dvs)), 8'(req.register_pair_operand / dvs)};
    end
    if (take) begin
      dh_q <= {flags_in.d, flags_in.h};
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_lat_normal: assert property (take && dvs != 8'h00 |-> ##26 done)
    else $error("done not 26 cycles after start");
  a_lat_zero: assert property (take && dvs == 8'h00 |-> ##10 done)
    else $error("done not 10 cycles after zero-divisor start");
  a_busy_hold: assert property (take |=> !ready [*8])
    else $error("ready returned too early");
  a_zero_flags: assert property (take && dvs == 8'h00 |-> ##10
    (!rsp.pair_we && rsp.flags.v && rsp.flags.z && !rsp.flags.c))
    else $error("zero divisor result wrong");
  a_we_done: assert property (rsp.pair_we |-> done)
    else $error("pair write outside done");
  a_sign_msb: assert property (done && rsp.pair_we |-> rsp.flags.s == rsp.pair[7])
    else $error("sign not quotient msb");
  a_carry_ovf: assert property (done && rsp.flags.c |-> rsp.flags.v)
    else $error("carry without overflow");
  a_pair_value: assert property (done && !rsp.flags.v |-> rsp.pair == exp_q)
    else $error("pair value wrong");
  a_keep_dh: assert property (done |-> {rsp.flags.d, rsp.flags.h} == dh_q)
    else $error("d or h flag altered");
endmodule : udv_divider_monitor

bind udv_divider udv_divider_monitor mon (.core_clk(core_clk), .srst(srst), .start(start),
  .req(req), .flags_in(flags_in), .ready(ready), .done(done), .rsp(rsp));

// ---- verification/udv_regfile_model.sv ----
// register-pair model on the far side of the divider
`timescale 1ns/1ps
module udv_regfile_model (
  input wire logic core_clk,
  input wire logic srst,
  input udv_pkg::udv_rsp_s rsp,
  output logic [15:0] pair_q
);
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pair_q <= udv_pkg::PAIR_RST;
    end else if (rsp.pair_we) begin
      pair_q <= rsp.pair;
    end
  end
endmodule : udv_regfile_model

// ---- verilog/udv_divider.sv ----
// unsigned 16-by-8 divide datapath driven by the instruction sequencer
`timescale 1ns/1ps

// Operation
// - divide 16-bit pair by 8-bit source
// - both operands unsigned, no sign handling
// - quotient goes to low byte of pair
// - remainder goes to high byte of pair
// - pair contents meaningless when quotient overflows
// - carry: overflow with nine-bit quotient only
// - zero: divisor or quotient equals zero
// - sign: msb of 8-bit quotient
// - overflow: quotient >= 256 or divisor zero
module udv_divider (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic start,
  input udv_pkg::udv_req_s req,
  input udv_pkg::udv_flags_s flags_in,
  output logic ready,
  output logic done,
  output udv_pkg::udv_rsp_s rsp
);

  // ==========================================================================
  // declarations
  udv_pkg::udv_state_e state_q;
  udv_pkg::udv_state_e state_d;
  logic [udv_pkg::CNT_W-1:0] cyc_q;
  logic [udv_pkg::CNT_W-1:0] lat_q;
  logic [udv_pkg::STEP_W-1:0] step_q;
  logic [udv_pkg::DIVIDEND_W-1:0] dividend_q;
  logic [udv_pkg::DIVISOR_W-1:0] divisor_q;
  logic [udv_pkg::DIVISOR_W-1:0] rem_q;
  logic [udv_pkg::DIVIDEND_W-1:0] quo_q;
  logic d_keep_q;
  logic h_keep_q;
  logic [udv_pkg::DIVISOR_W-1:0] divisor_sel;
  logic div_by_zero;
  logic [udv_pkg::DIVISOR_W:0] trial;
  logic trial_fits;
  logic last_cycle;
  logic quo_ge_256;
  logic quo_ge_512;
  logic take;
  logic finish;
  logic [udv_pkg::DIVISOR_W:0] trial_diff;
  logic [udv_pkg::DIVIDEND_W-1:0] dividend_shr9;
  logic [udv_pkg::DIVIDEND_W-1:0] divisor_wide;
  logic res_we_q;
  logic [udv_pkg::DIVIDEND_W-1:0] res_pair_q;
  udv_pkg::udv_flags_s res_flags_q;

  // ==========================================================================
  // source operand select
  always_comb begin
    case (req.mode)
      udv_pkg::UDV_SRC_REGISTER: divisor_sel = req.register_operand;
      udv_pkg::UDV_SRC_INDIRECT: divisor_sel = req.indirect_register_operand;
      udv_pkg::UDV_SRC_IMMEDIATE: divisor_sel = req.immediate_operand;
      default: divisor_sel = req.register_operand;
    endcase
  end

  // a request is only accepted while idle; starts during a divide are dropped
  assign take = start && (state_q == udv_pkg::UDV_IDLE);
  assign ready = (state_q == udv_pkg::UDV_IDLE);
  assign done = (state_q == udv_pkg::UDV_DONE);
  assign rsp = '{pair_we: res_we_q, pair: res_pair_q, flags: res_flags_q};
  assign div_by_zero = (divisor_q == udv_pkg::BYTE_ZERO);

  // ==========================================================================
  // sequencing
  assign last_cycle = (cyc_q == (lat_q - udv_pkg::CNT_ONE));
  assign finish = (state_q == udv_pkg::UDV_RUN) && last_cycle;

  always_comb begin
    state_d = state_q;
    case (state_q)
      udv_pkg::UDV_IDLE: begin
        if (take) begin
          state_d = udv_pkg::UDV_RUN;
        end
      end
      udv_pkg::UDV_RUN: begin
        if (last_cycle) begin
          state_d = udv_pkg::UDV_DONE;
        end
      end
      udv_pkg::UDV_DONE: begin
        state_d = udv_pkg::UDV_IDLE;
      end
      default: begin
        state_d = udv_pkg::UDV_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= udv_pkg::UDV_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // cycle counter: the start cycle counts as cycle 0
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cyc_q <= udv_pkg::CNT_ZERO;
    end else if (take) begin
      cyc_q <= udv_pkg::CNT_ONE;
    end else if (state_q == udv_pkg::UDV_RUN) begin
      cyc_q <= cyc_q + udv_pkg::CNT_ONE;
    end else begin
      cyc_q <= udv_pkg::CNT_ZERO;
    end
  end

  // latency picked once from the divisor seen at start
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lat_q <= udv_pkg::LAT_NORMAL;
    end else if (take) begin
      if (divisor_sel == udv_pkg::BYTE_ZERO) begin
        lat_q <= udv_pkg::LAT_ZERO;
      end else begin
        lat_q <= udv_pkg::LAT_NORMAL;
      end
    end
  end

  // ==========================================================================
  // operand capture
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dividend_q <= udv_pkg::PAIR_RST;
      divisor_q <= udv_pkg::BYTE_ZERO;
      d_keep_q <= 1'h0;
      h_keep_q <= 1'h0;
    end else if (take) begin
      dividend_q <= req.register_pair_operand;
      divisor_q <= divisor_sel;
      d_keep_q <= flags_in.d;
      h_keep_q <= flags_in.h;
    end
  end

  // ==========================================================================
  // restoring division, one quotient bit per cycle
  // the full 16-bit quotient is built so that the zero flag is exact on overflow;
  // zero-extended compare keeps everything unsigned
  assign trial = {rem_q, quo_q[udv_pkg::DIVIDEND_W-1]};
  assign trial_fits = (trial >= {1'h0, divisor_q});
  assign trial_diff = trial - {1'h0, divisor_q};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      step_q <= udv_pkg::STEP_ZERO;
      rem_q <= udv_pkg::BYTE_ZERO;
      quo_q <= udv_pkg::PAIR_RST;
    end else if (take) begin
      step_q <= udv_pkg::STEP_ZERO;
      rem_q <= udv_pkg::BYTE_ZERO;
      quo_q <= req.register_pair_operand;
    end else if ((state_q == udv_pkg::UDV_RUN) && !div_by_zero
                 && (step_q != udv_pkg::STEP_COUNT)) begin
      step_q <= step_q + udv_pkg::STEP_ONE;
      // remainder stays below the divisor, so its low 8 bits suffice
      if (trial_fits) begin
        rem_q <= trial_diff[udv_pkg::DIVISOR_W-1:0];
      end else begin
        rem_q <= trial[udv_pkg::DIVISOR_W-1:0];
      end
      quo_q <= {quo_q[udv_pkg::DIVIDEND_W-2:0], trial_fits};
    end
  end

  // ==========================================================================
  // overflow classification straight from the operands, no extra cycles
  assign dividend_shr9 = dividend_q >> udv_pkg::NINE_BIT_SHIFT;
  assign divisor_wide = {udv_pkg::BYTE_ZERO, divisor_q};
  assign quo_ge_256 = (dividend_q[udv_pkg::PAIR_HI_MSB:udv_pkg::PAIR_HI_LSB]
                       >= divisor_q);
  assign quo_ge_512 = (dividend_shr9 >= divisor_wide);

  // ==========================================================================
  // result write strobe, one cycle with done
  always_ff @(posedge core_clk) begin
    if (srst) begin
      res_we_q <= 1'h0;
    end else begin
      // pair is written even on overflow; its value is then not meaningful
      res_we_q <= finish && !div_by_zero;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      res_pair_q <= udv_pkg::PAIR_RST;
    end else if (finish) begin
      res_pair_q[udv_pkg::PAIR_HI_MSB:udv_pkg::PAIR_HI_LSB] <= rem_q;
      res_pair_q[udv_pkg::PAIR_LO_MSB:udv_pkg::PAIR_LO_LSB] <=
        quo_q[udv_pkg::PAIR_LO_MSB:udv_pkg::PAIR_LO_LSB];
    end
  end

  // ==========================================================================
  // flags, registered on the final cycle and held until the next one
  always_ff @(posedge core_clk) begin
    if (srst) begin
      res_flags_q <= '0;
    end else if (finish) begin
      res_flags_q.v <= div_by_zero || quo_ge_256;
      res_flags_q.c <= !div_by_zero && quo_ge_256 && !quo_ge_512;
      res_flags_q.z <= div_by_zero || (quo_q == udv_pkg::PAIR_RST);
      res_flags_q.s <= !div_by_zero && quo_q[udv_pkg::QUO_MSB];
      res_flags_q.d <= d_keep_q;
      res_flags_q.h <= h_keep_q;
    end
  end

endmodule : udv_divider

// ---- verilog/udv_pkg.sv ----
// shared types and constants for the unsigned 16-by-8 divide datapath
package udv_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned DIVIDEND_W = 16;
  localparam int unsigned DIVISOR_W = 8;
  localparam int unsigned CNT_W = 5;
  localparam int unsigned STEP_W = 5;

  // ==========================================================================
  // field positions inside the destination register pair
  localparam int unsigned PAIR_HI_MSB = 15;
  localparam int unsigned PAIR_HI_LSB = 8;
  localparam int unsigned PAIR_LO_MSB = 7;
  localparam int unsigned PAIR_LO_LSB = 0;
  localparam int unsigned QUO_MSB = 7;
  // quotient >= 2^9 exactly when dividend >> 9 >= divisor
  localparam int unsigned NINE_BIT_SHIFT = 9;

  // ==========================================================================
  // timing, in core_clk cycles from the start cycle to the done cycle
  localparam logic [CNT_W-1:0] LAT_NORMAL = 5'h1a;
  localparam logic [CNT_W-1:0] LAT_ZERO = 5'h0a;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  // one restoring step per quotient bit of the full 16-bit quotient
  localparam logic [STEP_W-1:0] STEP_COUNT = 5'h10;
  localparam logic [STEP_W-1:0] STEP_ONE = 5'h01;
  localparam logic [STEP_W-1:0] STEP_ZERO = 5'h00;

  // ==========================================================================
  // reset values
  localparam logic [DIVIDEND_W-1:0] PAIR_RST = 16'h0000;
  localparam logic [DIVISOR_W-1:0] BYTE_ZERO = 8'h00;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    UDV_SRC_REGISTER = 2'h0,
    UDV_SRC_INDIRECT = 2'h1,
    UDV_SRC_IMMEDIATE = 2'h2
  } udv_src_mode_e;

  typedef enum logic [1:0] {
    UDV_IDLE = 2'h0,
    UDV_RUN = 2'h1,
    UDV_DONE = 2'h2
  } udv_state_e;

  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
  } udv_flags_s;

  typedef struct packed {
    udv_src_mode_e mode;
    logic [DIVIDEND_W-1:0] register_pair_operand;
    logic [DIVISOR_W-1:0] register_operand;
    logic [DIVISOR_W-1:0] indirect_register_operand;
    logic [DIVISOR_W-1:0] immediate_operand;
  } udv_req_s;

  typedef struct packed {
    logic pair_we;
    logic [DIVIDEND_W-1:0] pair;
    udv_flags_s flags;
  } udv_rsp_s;

endpackage : udv_pkg
